// File: vca_map.vh
`ifndef VCA_MAP_VH
`define VCA_MAP_VH
`define VCA_CTL_ADDR 4'h0
`define VCA_STAT_ADDR 4'h4
`define VCA_IRQ_STAT_ADDR 4'h8
`define VCA_IRQ_MASK_ADDR 4'hC
`define VCA_RST_BIT 31
`define VCA_BLK_BIT 30
`define VCA_RAW_FIELD_ID_ENABLE_BIT 21
`define VCA_FIELD_POLARITY_INVERT_BIT 20
`define VCA_EXT_BIT 19
`define VCA_EN_BIT 15
`define VCA_FRM_BIT 30
`define VCA_F2_BIT 29
`define VCA_F1_BIT 28
`define VCA_CTL_RESET 32'h40020030
`define VCA_CTL_WMASK 32'h403FFDF7
`define VCA_FLUSH_CYCLES 4'h4
`endif

// File: vca_control.v
`timescale 1ns/1ps
`default_nettype none
`include "vca_map.vh"
module vca_control (
    input wire clock,
    input wire rstn,
    input wire [3:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    input wire dma_busy,
    input wire frame_start,
    input wire field_end,
    input wire frame_end,
    input wire detected_field,
    output reg fifo_flush,
    output reg dma_event_en,
    output reg capture_enable,
    output reg raw_field_id_enable,
    output reg field_polarity_invert,
    output reg external_timing_select,
    output reg field_is_two,
    output reg field_event,
    output reg frame_event,
    output reg irq
);
// ----------------------------------------
// state codes
// ----------------------------------------
localparam ST_IDLE = 3'b001;
localparam ST_WAIT = 3'b010;
localparam ST_FLSH = 3'b100;
localparam SY_RUN = 3'b001;
localparam SY_FLD = 3'b010;
localparam SY_FRM = 3'b100;
// ----------------------------------------
// decode helpers
// ----------------------------------------
function addr_hit;
    input [3:0] a;
    input [3:0] target;
    begin
        addr_hit = (a == target);
    end
endfunction
// ----------------------------------------
// storage
// ----------------------------------------
reg [31:0] ctl_ff;
reg [2:0] stat_ff;
reg [2:0] irq_stat_ff;
reg [2:0] irq_mask_ff;
reg [2:0] st_ff;
reg [2:0] sy_ff;
reg [3:0] cnt_ff;
reg [31:0] nxt_ctl;
reg [2:0] nxt_st;
reg [2:0] nxt_sy;
reg [3:0] nxt_cnt;
reg [2:0] nxt_irq_mask;
reg [31:0] nxt_rdata;
wire [2:0] nxt_stat;
wire [2:0] nxt_irq_stat;
wire ctl_wr;
wire stat_wr;
wire istat_wr;
wire imask_wr;
wire blocked;
wire ev_ok;
wire fld_two;
wire rst_done;
wire [2:0] ev_set;
wire [2:0] ev;
// ----------------------------------------
// decodes
// ----------------------------------------
assign ctl_wr = wr && addr_hit(addr, `VCA_CTL_ADDR);
assign stat_wr = wr && addr_hit(addr, `VCA_STAT_ADDR);
assign istat_wr = wr && addr_hit(addr, `VCA_IRQ_STAT_ADDR);
assign imask_wr = wr && addr_hit(addr, `VCA_IRQ_MASK_ADDR);
assign blocked = ctl_ff[`VCA_BLK_BIT];
assign ev_ok = (sy_ff == SY_RUN) && !blocked && ctl_ff[`VCA_EN_BIT];
assign fld_two = detected_field ^ ctl_ff[`VCA_FIELD_POLARITY_INVERT_BIT];
assign rst_done = (st_ff == ST_FLSH) && (cnt_ff == 4'h1);
assign ev_set = {frame_end, field_end && fld_two, field_end && !fld_two};
assign ev = ev_ok ? ev_set : 3'h0;
// ----------------------------------------
// channel reset and control register
// ----------------------------------------
always @*
begin
    nxt_ctl = ctl_ff;
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    if (ctl_wr)
    begin
        nxt_ctl = (ctl_ff & ~`VCA_CTL_WMASK) | (wdata & `VCA_CTL_WMASK);
    end
    case (st_ff)
        ST_IDLE:
        begin
            if (ctl_wr && wdata[`VCA_RST_BIT])
            begin
                nxt_st = ST_WAIT;
                nxt_ctl = ctl_ff;
                nxt_ctl[`VCA_RST_BIT] = 1'b1;
            end
        end
        ST_WAIT:
        begin
            nxt_ctl[`VCA_RST_BIT] = 1'b1;
            if (!dma_busy)
            begin
                nxt_st = ST_FLSH;
                nxt_cnt = `VCA_FLUSH_CYCLES;
            end
        end
        ST_FLSH:
        begin
            nxt_ctl[`VCA_RST_BIT] = 1'b1;
            nxt_cnt = cnt_ff - 4'h1;
            if (rst_done)
            begin
                nxt_st = ST_IDLE;
                nxt_ctl = `VCA_CTL_RESET;
            end
        end
        default:
        begin
            nxt_st = ST_IDLE;
        end
    endcase
end
// ----------------------------------------
// resync after unblock
// ----------------------------------------
always @*
begin
    nxt_sy = sy_ff;
    case (sy_ff)
        SY_RUN:
        begin
            if (blocked)
            begin
                nxt_sy = SY_FLD;
            end
        end
        SY_FLD:
        begin
            if (!blocked && frame_start)
            begin
                nxt_sy = SY_FRM;
            end
        end
        SY_FRM:
        begin
            if (blocked)
            begin
                nxt_sy = SY_FLD;
            end
            else if (frame_start)
            begin
                nxt_sy = SY_RUN;
            end
        end
        default:
        begin
            nxt_sy = SY_FLD;
        end
    endcase
end
// ----------------------------------------
// sticky status bits, set wins over write clear; end of channel reset clears stat
// ----------------------------------------
genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_stat
        assign nxt_stat[gi] = rst_done ? 1'b0 :
            (ev[gi] | (stat_ff[gi] & ~(stat_wr & wdata[`VCA_F1_BIT + gi])));
        assign nxt_irq_stat[gi] = ev[gi] | (irq_stat_ff[gi] & ~(istat_wr & wdata[gi]));
    end
endgenerate
// ----------------------------------------
// interrupt mask
// ----------------------------------------
always @*
begin
    nxt_irq_mask = irq_mask_ff;
    if (imask_wr)
    begin
        nxt_irq_mask = wdata[2:0];
    end
end
// ----------------------------------------
// read mux
// ----------------------------------------
always @*
begin
    nxt_rdata = 32'h00000000;
    if (rd)
    begin
        case (addr)
            `VCA_CTL_ADDR: nxt_rdata = ctl_ff;
            `VCA_STAT_ADDR: nxt_rdata = {1'b0, stat_ff, 28'h0000000};
            `VCA_IRQ_STAT_ADDR: nxt_rdata = {29'h00000000, irq_stat_ff};
            `VCA_IRQ_MASK_ADDR: nxt_rdata = {29'h00000000, irq_mask_ff};
            default: nxt_rdata = 32'h00000000;
        endcase
    end
end
// ----------------------------------------
// core registers
// ----------------------------------------
always @(posedge clock or negedge rstn)
begin
    if (!rstn)
    begin
        ctl_ff <= `VCA_CTL_RESET;
        stat_ff <= 3'h0;
        irq_stat_ff <= 3'h0;
        irq_mask_ff <= 3'h0;
        st_ff <= ST_IDLE;
        sy_ff <= SY_FLD;
        cnt_ff <= 4'h0;
    end
    else
    begin
        ctl_ff <= nxt_ctl;
        stat_ff <= nxt_stat;
        irq_stat_ff <= nxt_irq_stat;
        irq_mask_ff <= nxt_irq_mask;
        st_ff <= nxt_st;
        sy_ff <= nxt_sy;
        cnt_ff <= nxt_cnt;
    end
end
// ----------------------------------------
// read data
// ----------------------------------------
always @(posedge clock or negedge rstn)
begin
    if (!rstn)
    begin
        rdata <= 32'h00000000;
    end
    else
    begin
        rdata <= nxt_rdata;
    end
end
// ----------------------------------------
// flush and dma gating
// ----------------------------------------
always @(posedge clock or negedge rstn)
begin
    if (!rstn)
    begin
        fifo_flush <= 1'b1;
        dma_event_en <= 1'b0;
    end
    else
    begin
        fifo_flush <= nxt_ctl[`VCA_BLK_BIT] || (nxt_st == ST_FLSH);
        dma_event_en <= (nxt_sy == SY_RUN) && !nxt_ctl[`VCA_BLK_BIT];
    end
end
// ----------------------------------------
// configuration outputs
// ----------------------------------------
always @(posedge clock or negedge rstn)
begin
    if (!rstn)
    begin
        capture_enable <= 1'b0;
        raw_field_id_enable <= 1'b0;
        field_polarity_invert <= 1'b0;
        external_timing_select <= 1'b0;
    end
    else
    begin
        capture_enable <= nxt_ctl[`VCA_EN_BIT];
        raw_field_id_enable <= nxt_ctl[`VCA_RAW_FIELD_ID_ENABLE_BIT];
        field_polarity_invert <= nxt_ctl[`VCA_FIELD_POLARITY_INVERT_BIT];
        external_timing_select <= nxt_ctl[`VCA_EXT_BIT];
    end
end
// ----------------------------------------
// events and interrupt
// ----------------------------------------
always @(posedge clock or negedge rstn)
begin
    if (!rstn)
    begin
        field_is_two <= 1'b0;
        field_event <= 1'b0;
        frame_event <= 1'b0;
        irq <= 1'b0;
    end
    else
    begin
        field_is_two <= fld_two;
        field_event <= ev[1] | ev[0];
        frame_event <= ev[2];
        irq <= |(nxt_irq_stat & irq_mask_ff);
    end
end
endmodule
`default_nettype wire

// File: vca_sva.sv
`timescale 1ns/1ps
`default_nettype none
module vca_sva (
    input wire clock,
    input wire rstn,
    input wire [3:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    input wire frame_start,
    input wire detected_field,
    input wire dma_event_en,
    input wire capture_enable,
    input wire field_polarity_invert,
    input wire field_is_two,
    input wire field_event,
    input wire frame_event,
    input wire fifo_flush
);
default clocking @(posedge clock); endclocking
default disable iff (!rstn);
chk_resv_zero: assert property (rd && !addr |=> rdata[29:22] == 8'h00)
    else $error("reserved bits set");
chk_en_read: assert property (rd && !addr |=> rdata[15] == $past(capture_enable))
    else $error("enable readback");
chk_frame_gate: assert property (frame_event |-> $past(dma_event_en))
    else $error("frame event blocked");
chk_field_gate: assert property (field_event |-> $past(dma_event_en))
    else $error("field event blocked");
chk_unblock_sync: assert property ($rose(dma_event_en) |-> $past(frame_start))
    else $error("unblock off frame");
chk_field_pol: assert property ($past(rstn) |->
    field_is_two == ($past(detected_field) ^ $past(field_polarity_invert)))
    else $error("field polarity");
chk_reset_clear: assert property (wr && !addr && wdata[31] |-> ##[1:60] !capture_enable)
    else $error("enable not cleared");
chk_block_flush: assert property (wr && !addr && wdata[30] |-> ##[1:2] fifo_flush)
    else $error("no flush");
endmodule
`default_nettype wire

// File: vca_src.sv
`timescale 1ns/1ps
`default_nettype none
module vca_src (
    input wire logic clock,
    input wire logic rstn,
    output logic frame_start,
    output logic field_end,
    output logic frame_end,
    output logic detected_field,
    output logic dma_busy
);
logic [4:0] c_ff;
always @(posedge clock or negedge rstn)
    c_ff <= !rstn ? 5'h00 : c_ff + 5'h01;
assign frame_start = c_ff == 5'h00;
assign field_end = &c_ff[3:0];
assign frame_end = &c_ff;
assign detected_field = c_ff[4];
assign dma_busy = &c_ff[2:1];
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "vca_map.vh"
bind vca_control vca_sva vca_sva_i (.*);
module tb;
logic clock = 0, rstn = 0, wr = 0, rd = 0;
logic [3:0] addr = 0;
logic [31:0] wdata = 0, v, s = 32'h8946;
wire [31:0] rdata;
wire frame_start, field_end, frame_end, detected_field, dma_busy, fifo_flush, dma_event_en;
wire capture_enable, raw_field_id_enable, field_polarity_invert, external_timing_select;
wire field_is_two, field_event, frame_event, irq;
int n_mismatch = 0, num_checks = 0, i;
always #5 clock = ~clock;
vca_src vca_src_i (.*);
vca_control vca_control_i (.*);
function logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
endfunction
task chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
        n_mismatch++;
        $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
endtask
task put(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clock);
    wr <= 0;
    #1;
endtask
task get(input logic [3:0] a);
    addr <= a;
    rd <= 1;
    @(posedge clock);
    rd <= 0;
    @(posedge clock);
    v = rdata;
    #1;
endtask
task report_and_stop;
    if (n_mismatch == 0 && num_checks > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
initial
begin
    repeat (16) @(posedge clock);
    rstn <= 1;
    @(posedge clock);
    get(0);
    chk("ctl", `VCA_CTL_RESET, v);
    for (i = 0; i < 8; i++)
    begin
        s = xs(s);
        put(0, s & 32'h7FFFFFFF);
        get(0);
        chk("ctl", s & `VCA_CTL_WMASK, v);
        chk("pins", s[21:19], {raw_field_id_enable, field_polarity_invert,
            external_timing_select});
    end
    put(0, 32'h8000);
    put(0, 32'h80000000);
    v = 32'h80000000;
    for (i = 0; i < 50 && v[31]; i++)
        get(0);
    chk("ctl", `VCA_CTL_RESET, v);
    chk("en", 0, capture_enable);
    put(4'hC, 7);
    put(0, 32'h8000);
    for (i = 0; i < 200 && frame_event !== 1; i++)
        @(negedge clock);
    chk("frame", 1, frame_event);
    @(posedge clock);
    put(0, 32'h40008000);
    chk("irq", 1, irq);
    put(4'hC, 0);
    get(4);
    chk("done", 1, v[30]);
    chk("irq", 0, irq);
    put(4, 32'h70000000);
    put(8, 7);
    repeat (40) @(posedge clock);
    get(4);
    chk("stat", 0, v[30:28]);
    chk("dma", 0, dma_event_en);
    get(2);
    chk("unmap", 0, v);
    report_and_stop;
end
endmodule
`default_nettype wire
